//--- rtl/tmr_defines.svh
// constants for the tunnel mode command relay: codes, field limits, timing
// assumes inclusion by bare name from design and verification files
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH
// rf command codes
`define TMR_RF_READ_FS      8'h06
`define TMR_RF_READ_TB      8'hB0
`define TMR_RF_WRITE_FS     8'h08
`define TMR_RF_WRITE_TB     8'hD6
// host serial command codes
`define TMR_CMD_QUERY       8'h28
`define TMR_CMD_ANS_OK      8'hF8
`define TMR_CMD_ANS_ERR     8'hE8
// response codes chosen for the relay
`define TMR_RSP_OK          8'h00
`define TMR_RSP_ERR         8'hFF
// field limits
`define TMR_CNT_MIN         8'h01
`define TMR_CNT_MAX         8'h0F
`define TMR_ID_BYTES        8
// fixed top bits of the query start address
`define TMR_ADDR_TOP        2'h1
// wait tick: 1 ms at 125 MHz, 8 ns period
`define TMR_TICK_NS         1000000
`define TMR_CLK_NS          8
`define TMR_TICK_CYC        (`TMR_TICK_NS / `TMR_CLK_NS)
`endif

//--- rtl/tmr_pkg.sv
// types shared by both ends of the tunnel mode command relay
// assumes tmr_defines.svh for the numeric constants
package tmr_pkg;
  // serial command kinds seen by the device
  typedef enum logic [1:0] {
    TMR_KIND_QUERY,
    TMR_KIND_ANSWER,
    TMR_KIND_OTHER
  } tmr_kind_t;
  // device transaction states
  typedef enum logic [2:0] {
    TMR_IDLE,
    TMR_PARSE,
    TMR_WAIT_QUERY,
    TMR_SEND_QUERY,
    TMR_WAIT_ANSWER,
    TMR_SEND_ANSWER
  } tmr_dev_state_t;
  // host states
  typedef enum logic [2:0] {
    TMR_H_IDLE,
    TMR_H_QUERY,
    TMR_H_READ,
    TMR_H_ANSWER,
    TMR_H_DONE
  } tmr_host_state_t;
endpackage : tmr_pkg

//--- rtl/tmr_link_if.sv
// serial-side link between host end and device end, byte framed
// assumes both ends on one clock; the bench drives clk and rst_n
`timescale 1ns/10ps
`default_nettype none
interface tmr_link_if (
  input wire logic clk,
  input wire logic rst_n
);
  // active-low alert from device to host
  logic       host_alert_n;
  // host to device: addressed (ack start), byte strobe, end of command
  logic       cmd_ack;
  logic       cmd_valid;
  logic [7:0] cmd_byte;
  logic       cmd_end;
  // device to host response bytes
  logic       rsp_valid;
  logic [7:0] rsp_byte;
  logic       rsp_last;
  modport dev (
    input  clk, rst_n, cmd_ack, cmd_valid, cmd_byte, cmd_end,
    output host_alert_n, rsp_valid, rsp_byte, rsp_last
  );
  modport host (
    input  clk, rst_n, host_alert_n, rsp_valid, rsp_byte, rsp_last,
    output cmd_ack, cmd_valid, cmd_byte, cmd_end
  );
endinterface : tmr_link_if
`default_nettype wire

//--- rtl/tmr_host_end.sv
// host end: on alert sends QUERY, collects response, sends ANSWER
// assumes the device end on the same clock through tmr_link_if
`include "tmr_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module tmr_host_end (
  // clock and reset
  input  wire logic  CLK_SYS_I,
  input  wire logic  ARST_N_I,
  // link
  tmr_link_if.host   LINK,
  // user side
  input  wire logic  ANS_ERR_I,
  output logic       BUSY_O,
  output logic [7:0] LEN_O,
  output logic [7:0] RSP_O
);
  tmr_pkg::tmr_host_state_t state, next_state;
  logic [1:0] idx, next_idx;
  logic [7:0] len, next_len;
  logic [7:0] rsp, next_rsp;
  logic       ack, next_ack, vld, next_vld, fin, next_fin;
  logic [7:0] byt, next_byt;
  logic       alert_q1, alert_q2;
  // ****************************************
  // alert synchroniser
  // ****************************************
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      alert_q1 <= 1'b1;
      alert_q2 <= 1'b1;
    end else begin
      alert_q1 <= LINK.host_alert_n;
      alert_q2 <= alert_q1;
    end
  end
  // ****************************************
  // host sequence
  // ****************************************
  always_comb begin
    next_state = state;
    next_idx   = idx;
    next_len   = len;
    next_rsp   = rsp;
    next_ack   = 1'b0;
    next_vld   = 1'b0;
    next_fin   = 1'b0;
    next_byt   = byt;
    case (state)
      tmr_pkg::TMR_H_IDLE: begin
        if (!alert_q2) begin
          next_ack   = 1'b1;
          next_state = tmr_pkg::TMR_H_QUERY;
        end
      end
      tmr_pkg::TMR_H_QUERY: begin
        next_vld   = 1'b1;
        next_fin   = 1'b1;
        next_byt   = `TMR_CMD_QUERY;
        next_idx   = 2'd0;
        next_state = tmr_pkg::TMR_H_READ;
      end
      tmr_pkg::TMR_H_READ: begin
        if (LINK.rsp_valid) begin
          next_idx = idx + 2'd1;
          if (idx == 2'd0) begin
            next_rsp = LINK.rsp_byte;
          end
          if (LINK.rsp_last) begin
            next_len   = LINK.rsp_byte;
            next_ack   = 1'b1;
            next_state = tmr_pkg::TMR_H_ANSWER;
          end
        end
      end
      tmr_pkg::TMR_H_ANSWER: begin
        next_vld   = 1'b1;
        next_fin   = 1'b1;
        next_byt   = ANS_ERR_I ? `TMR_CMD_ANS_ERR : `TMR_CMD_ANS_OK;
        next_state = tmr_pkg::TMR_H_DONE;
      end
      tmr_pkg::TMR_H_DONE: begin
        if (LINK.rsp_valid && LINK.rsp_last) begin
          next_rsp   = LINK.rsp_byte;
          next_state = tmr_pkg::TMR_H_IDLE;
        end
      end
      default: next_state = tmr_pkg::TMR_H_IDLE;
    endcase
  end
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state <= tmr_pkg::TMR_H_IDLE;
      idx   <= 2'd0;
      len   <= 8'h00;
      rsp   <= 8'h00;
      ack   <= 1'b0;
      vld   <= 1'b0;
      fin   <= 1'b0;
      byt   <= 8'h00;
    end else begin
      state <= next_state;
      idx   <= next_idx;
      len   <= next_len;
      rsp   <= next_rsp;
      ack   <= next_ack;
      vld   <= next_vld;
      fin   <= next_fin;
      byt   <= next_byt;
    end
  end
  logic busy;
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      busy <= 1'b0;
    end else begin
      busy <= (next_state != tmr_pkg::TMR_H_IDLE);
    end
  end
  assign LINK.cmd_ack   = ack;
  assign LINK.cmd_valid = vld;
  assign LINK.cmd_byte  = byt;
  assign LINK.cmd_end   = fin;
  assign BUSY_O         = busy;
  assign LEN_O          = len;
  assign RSP_O          = rsp;
endmodule : tmr_host_end
`default_nettype wire

//--- rtl/tmr_dev_end.sv
// device end of the tunnel mode command relay
// assumes rf bytes pre-framed by a receiver; serial link via tmr_link_if
`include "tmr_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module tmr_dev_end #(
  parameter int TICK_CYC = `TMR_TICK_CYC
) (
  // clock and reset
  input  wire logic  CLK_SYS_I,
  input  wire logic  ARST_N_I,
  // link to host
  tmr_link_if.dev    LINK,
  // rf command bytes
  input  wire logic  RF_VALID_I,
  input  wire logic [7:0] RF_BYTE_I,
  input  wire logic  RF_END_I,
  input  wire logic  RF_TYPEB_I,
  // configuration
  input  wire logic [7:0] QUERY_WAIT_LIMIT_I,
  input  wire logic [7:0] ANSWER_WAIT_LIMIT_I,
  input  wire logic [1:0] ENC_MODE_I,
  // results
  output logic       RF_ERR_O,
  output logic       ANS_DONE_O,
  output logic       ANS_OK_O,
  output logic       TIMEOUT_O
);
  tmr_pkg::tmr_dev_state_t state, next_state;
  logic [7:0]  pos, next_pos;
  logic [7:0]  k, next_k, m, next_m;
  logic [15:0] svc, next_svc, addr, next_addr;
  logic        bad, next_bad, is_rd, next_is_rd, svc_hi, next_svc_hi;
  logic [7:0]  svc_lo, next_svc_lo;
  logic [7:0]  wait_cnt, next_wait_cnt;
  logic        paused, next_paused, first, next_first;
  logic        alert_n, next_alert_n;
  logic        rv, next_rv, rl, next_rl;
  logic [7:0]  rb, next_rb;
  logic [1:0]  ri, next_ri;
  logic        err, next_err, done, next_done, ok, next_ok, tmo, next_tmo;
  logic [31:0] tick_cnt;
  logic        tick;
  // ****************************************
  // wait tick
  // ****************************************
  // free-running tick
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_cnt == 32'(TICK_CYC - 1));
      tick_cnt <= (tick_cnt == 32'(TICK_CYC - 1)) ? 32'h0000_0000 : tick_cnt + 32'd1;
    end
  end
  // ****************************************
  // transaction control
  // ****************************************
  logic [7:0] limit;
  always_comb begin
    next_state = state;  next_pos = pos;  next_k = k;  next_m = m;
    next_svc = svc;  next_addr = addr;  next_bad = bad;  next_is_rd = is_rd;
    next_svc_hi = svc_hi;  next_svc_lo = svc_lo;  next_wait_cnt = wait_cnt;
    next_paused = paused;  next_first = first;  next_alert_n = alert_n;
    next_rv = 1'b0;  next_rl = 1'b0;  next_rb = rb;  next_ri = ri;
    next_err = 1'b0;  next_done = 1'b0;  next_ok = ok;  next_tmo = 1'b0;
    limit = (state == tmr_pkg::TMR_WAIT_QUERY) ? QUERY_WAIT_LIMIT_I : ANSWER_WAIT_LIMIT_I;
    case (state)
      tmr_pkg::TMR_IDLE: begin
        if (RF_VALID_I) begin
          next_pos = 8'd1;  next_bad = 1'b0;  next_k = 8'h00;  next_m = 8'h00;
          next_svc_hi = 1'b1;  next_first = 1'b1;
          // frames without a block count report a clean address, not the last one
          next_addr = {`TMR_ADDR_TOP, ENC_MODE_I, 12'h000};
          next_is_rd = RF_TYPEB_I ? (RF_BYTE_I == `TMR_RF_READ_TB)
                                  : (RF_BYTE_I == `TMR_RF_READ_FS);
          if (RF_TYPEB_I ? (RF_BYTE_I == `TMR_RF_READ_TB || RF_BYTE_I == `TMR_RF_WRITE_TB)
                         : (RF_BYTE_I == `TMR_RF_READ_FS || RF_BYTE_I == `TMR_RF_WRITE_FS)) begin
            next_state = RF_END_I ? tmr_pkg::TMR_IDLE : tmr_pkg::TMR_PARSE;
          end
        end
      end
      tmr_pkg::TMR_PARSE: begin
        if (RF_VALID_I) begin
          next_pos = pos + 8'd1;
          // fields of a plain read frame
          if (is_rd && !RF_TYPEB_I) begin
            if (pos == 8'(`TMR_ID_BYTES + 1)) begin
              next_k = RF_BYTE_I;
              if (RF_BYTE_I < `TMR_CNT_MIN || RF_BYTE_I > `TMR_CNT_MAX) next_bad = 1'b1;
            end else if (pos > 8'(`TMR_ID_BYTES + 1) && pos <= 8'(`TMR_ID_BYTES + 1) + 8'(k << 1)) begin
              next_svc_hi = ~svc_hi;
              if (svc_hi) next_svc_lo = RF_BYTE_I;
              else if (pos == 8'(`TMR_ID_BYTES + 3)) next_svc = {svc_lo, RF_BYTE_I};
              else if (svc != {svc_lo, RF_BYTE_I}) next_bad = 1'b1;
            end else if (pos == 8'(`TMR_ID_BYTES + 2) + 8'(k << 1)) begin
              next_m = RF_BYTE_I;
              if (RF_BYTE_I < `TMR_CNT_MIN || RF_BYTE_I > `TMR_CNT_MAX) next_bad = 1'b1;
              next_addr = {`TMR_ADDR_TOP, ENC_MODE_I, 4'h0, RF_BYTE_I};
            end
          end
          if (RF_END_I) begin
            if (next_bad) begin
              next_err = 1'b1;
              next_state = tmr_pkg::TMR_IDLE;
            end else begin
              next_alert_n = 1'b0;
              next_wait_cnt = 8'h00;
              next_paused = 1'b0;
              next_state = tmr_pkg::TMR_WAIT_QUERY;
            end
          end
        end
      end
      tmr_pkg::TMR_WAIT_QUERY, tmr_pkg::TMR_WAIT_ANSWER: begin
        // pause from address ack to command end
        if (LINK.cmd_ack) next_paused = 1'b1;
        if (LINK.cmd_valid && LINK.cmd_end) begin
          next_paused = 1'b0;
          if (state == tmr_pkg::TMR_WAIT_QUERY && LINK.cmd_byte == `TMR_CMD_QUERY) begin
            next_alert_n = 1'b1;  next_ri = 2'd0;
            next_state = tmr_pkg::TMR_SEND_QUERY;
          end else if (state == tmr_pkg::TMR_WAIT_ANSWER &&
                       (LINK.cmd_byte == `TMR_CMD_ANS_OK || LINK.cmd_byte == `TMR_CMD_ANS_ERR)) begin
            next_ok = (LINK.cmd_byte == `TMR_CMD_ANS_OK);
            next_state = tmr_pkg::TMR_SEND_ANSWER;
          end
        end else if (tick && !paused && !LINK.cmd_ack) begin
          next_wait_cnt = wait_cnt + 8'd1;
          if (wait_cnt + 8'd1 >= limit) begin
            next_tmo = 1'b1;  next_alert_n = 1'b1;
            next_state = tmr_pkg::TMR_IDLE;
          end
        end
      end
      tmr_pkg::TMR_SEND_QUERY: begin
        next_rv = 1'b1;
        next_ri = ri + 2'd1;
        case (ri)
          2'd0: next_rb = `TMR_RSP_OK;
          2'd1: next_rb = addr[15:8];
          2'd2: next_rb = addr[7:0];
          default: begin
            next_rb = m;  next_rl = 1'b1;
            if (first) next_wait_cnt = 8'h00;
            next_first = 1'b0;
            next_state = tmr_pkg::TMR_WAIT_ANSWER;
          end
        endcase
      end
      tmr_pkg::TMR_SEND_ANSWER: begin
        next_rv = 1'b1;  next_rl = 1'b1;  next_rb = `TMR_RSP_OK;
        next_done = 1'b1;
        next_state = tmr_pkg::TMR_IDLE;
      end
      default: next_state = tmr_pkg::TMR_IDLE;
    endcase
  end
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state <= tmr_pkg::TMR_IDLE;  pos <= 8'h00;  k <= 8'h00;  m <= 8'h00;
      svc <= 16'h0000;  addr <= 16'h0000;  bad <= 1'b0;  is_rd <= 1'b0;
      svc_hi <= 1'b1;  svc_lo <= 8'h00;  wait_cnt <= 8'h00;  paused <= 1'b0;
      first <= 1'b0;  alert_n <= 1'b1;  rv <= 1'b0;  rl <= 1'b0;  rb <= 8'h00;
      ri <= 2'd0;  err <= 1'b0;  done <= 1'b0;  ok <= 1'b0;  tmo <= 1'b0;
    end else begin
      state <= next_state;  pos <= next_pos;  k <= next_k;  m <= next_m;
      svc <= next_svc;  addr <= next_addr;  bad <= next_bad;  is_rd <= next_is_rd;
      svc_hi <= next_svc_hi;  svc_lo <= next_svc_lo;  wait_cnt <= next_wait_cnt;
      paused <= next_paused;  first <= next_first;  alert_n <= next_alert_n;
      rv <= next_rv;  rl <= next_rl;  rb <= next_rb;  ri <= next_ri;
      err <= next_err;  done <= next_done;  ok <= next_ok;  tmo <= next_tmo;
    end
  end
  assign LINK.host_alert_n = alert_n;
  assign LINK.rsp_valid    = rv;
  assign LINK.rsp_byte     = rb;
  assign LINK.rsp_last     = rl;
  assign RF_ERR_O          = err;
  assign ANS_DONE_O        = done;
  assign ANS_OK_O          = ok;
  assign TIMEOUT_O         = tmo;
endmodule : tmr_dev_end
`default_nettype wire

//--- verification/tmr_link_properties.sv
// link checker for the tunnel mode command relay
// assumes instantiation beside tmr_link_if in the bench, one clock
`include "tmr_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module tmr_link_properties (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // link signals
  input wire logic       host_alert_n,
  input wire logic       cmd_ack,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic       cmd_end,
  input wire logic       rsp_valid,
  input wire logic [7:0] rsp_byte,
  input wire logic       rsp_last
);
  // ****
  // helper state
  // ****
  logic q_take;
  logic a_take;
  logic wait_ans;
  logic next_wait_ans;
  logic cmd_q;
  logic cmd_q2;
  logic burst_q;
  assign q_take = cmd_valid && cmd_end && cmd_byte == `TMR_CMD_QUERY && !host_alert_n;
  assign a_take = cmd_valid && cmd_end && wait_ans &&
                  (cmd_byte == `TMR_CMD_ANS_OK || cmd_byte == `TMR_CMD_ANS_ERR);
  always_comb next_wait_ans = q_take ? 1'b1 : (a_take ? 1'b0 : wait_ans);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_ans <= 1'b0;
      cmd_q    <= 1'b0;
      cmd_q2   <= 1'b0;
      burst_q  <= 1'b0;
    end else begin
      wait_ans <= next_wait_ans;
      cmd_q    <= cmd_valid && cmd_end;
      cmd_q2   <= cmd_q;
      burst_q  <= rsp_valid && !rsp_last;
    end
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_qrsp;
    rsp_valid && !rsp_last && rsp_byte == `TMR_RSP_OK
    ##1 rsp_valid && !rsp_last && rsp_byte[7:6] == `TMR_ADDR_TOP && rsp_byte[3:0] == 4'h0
    ##1 rsp_valid && !rsp_last ##1 rsp_valid && rsp_last;
  endsequence
  sequence s_arsp;
    rsp_valid && rsp_last && rsp_byte == `TMR_RSP_OK;
  endsequence
  AST_QUERY_DECODE: assert property (q_take |-> ##2 rsp_valid)
    else $error("query not answered");
  AST_QUERY_FORMAT: assert property (q_take |-> ##2 s_qrsp)
    else $error("query response malformed");
  AST_ANSWER_RSP: assert property (a_take |-> ##2 s_arsp)
    else $error("answer not acknowledged");
  AST_ALERT_RELEASE: assert property (q_take |-> ##[1:2] host_alert_n)
    else $error("alert held after query");
  AST_ALERT_CAUSE: assert property ($rose(host_alert_n) |-> $past(q_take) || $past(q_take, 2))
    else $error("alert released early");
  AST_RSP_CAUSE: assert property (rsp_valid && !burst_q |-> cmd_q2)
    else $error("response without command");
  AST_LAST_GAP: assert property (rsp_last && !(cmd_valid && cmd_end) |=> !rsp_valid)
    else $error("response runs past last byte");
  AST_CMD_ONE_BYTE: assert property (cmd_valid |-> cmd_end)
    else $error("command byte without end");
endmodule : tmr_link_properties
`default_nettype wire

//--- verification/tmr_tunnel_mode_command_relay_tb.sv
// bench: host and device ends joined, plus a second device on a driven link
// assumes the rtl files and the link checker are compiled first
`include "tmr_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module tmr_tunnel_mode_command_relay_tb;
  localparam int TICK = 4;
  localparam int QL2 = 5;
  localparam int AL2 = 6;
  localparam logic [7:0] CODES [3] = '{`TMR_RF_WRITE_FS, `TMR_RF_READ_TB, `TMR_RF_WRITE_TB};
  localparam logic [7:0] EK [5] = '{8'h00, 8'h10, 8'h01, 8'h01, 8'h03};
  localparam logic [7:0] EM [5] = '{8'h01, 8'h01, 8'h00, 8'h10, 8'h02};
  logic       clk, rst_n, rf_valid, rf_end, rf_typeb, sel2, ans_err;
  logic       rf_err, ans_done, ans_ok, tmo2, alert2_q, busy, tmo1;
  logic [1:0] enc_mode;
  logic [7:0] rf_byte, len, rsp, m;
  logic [7:0] rq[$];
  logic [7:0] fb[$];
  int         n_mismatch, n_checks, cyc, n_rferr, n_done, n_alert, n_rsp2, n_to;
  int         n_busy, n_tmo1;
  int         c_fall, c_last, c_to, d0, e0, a0;
  tmr_link_if link (.clk(clk), .rst_n(rst_n));
  tmr_link_if link2 (.clk(clk), .rst_n(rst_n));
  tmr_dev_end #(.TICK_CYC(TICK)) i_tmr_dev_end (.CLK_SYS_I(clk), .ARST_N_I(rst_n),
    .LINK(link.dev), .RF_VALID_I(rf_valid && !sel2), .RF_BYTE_I(rf_byte),
    .RF_END_I(rf_end && !sel2), .RF_TYPEB_I(rf_typeb), .QUERY_WAIT_LIMIT_I(8'hFF),
    .ANSWER_WAIT_LIMIT_I(8'hFF), .ENC_MODE_I(enc_mode), .RF_ERR_O(rf_err),
    .ANS_DONE_O(ans_done), .ANS_OK_O(ans_ok), .TIMEOUT_O(tmo1));
  tmr_dev_end #(.TICK_CYC(TICK)) i_tmr_dev_end_b (.CLK_SYS_I(clk), .ARST_N_I(rst_n),
    .LINK(link2.dev), .RF_VALID_I(rf_valid && sel2), .RF_BYTE_I(rf_byte),
    .RF_END_I(rf_end && sel2), .RF_TYPEB_I(rf_typeb), .QUERY_WAIT_LIMIT_I(8'(QL2)),
    .ANSWER_WAIT_LIMIT_I(8'(AL2)), .ENC_MODE_I(enc_mode), .RF_ERR_O(),
    .ANS_DONE_O(), .ANS_OK_O(), .TIMEOUT_O(tmo2));
  tmr_host_end i_tmr_host_end (.CLK_SYS_I(clk), .ARST_N_I(rst_n), .LINK(link.host),
    .ANS_ERR_I(ans_err), .BUSY_O(busy), .LEN_O(len), .RSP_O(rsp));
  tmr_link_properties i_tmr_link_properties (.clk(clk), .rst_n(rst_n),
    .host_alert_n(link.host_alert_n), .cmd_ack(link.cmd_ack), .cmd_valid(link.cmd_valid),
    .cmd_byte(link.cmd_byte), .cmd_end(link.cmd_end), .rsp_valid(link.rsp_valid),
    .rsp_byte(link.rsp_byte), .rsp_last(link.rsp_last));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ****
  // monitors, sampled mid-cycle
  // ****
  always @(negedge clk) begin
    cyc++;
    if (rf_err === 1'b1) n_rferr++;
    if (ans_done === 1'b1) n_done++;
    if (busy === 1'b1) n_busy++;
    if (tmo1 === 1'b1) n_tmo1++;
    if (link.rsp_valid === 1'b1) rq.push_back(link.rsp_byte);
    if (link.host_alert_n === 1'b0) n_alert++;
    if (link2.host_alert_n === 1'b0 && alert2_q === 1'b1) c_fall = cyc;
    alert2_q = link2.host_alert_n;
    if (link2.rsp_valid === 1'b1) n_rsp2++;
    if (link2.rsp_last === 1'b1) c_last = cyc;
    if (tmo2 === 1'b1) begin
      n_to++;
      c_to = cyc;
    end
  end
  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk
  task automatic wait_until(ref int c, input int v, input int lim);
    for (int i = 0; i < lim && c < v; i++) @(posedge clk);
    chk(32'(c >= v), 32'h1);
  endtask : wait_until
  task automatic rf_frame();
    foreach (fb[i]) begin
      @(posedge clk);
      rf_valid <= 1'b1;
      rf_byte  <= fb[i];
      rf_end   <= (i == fb.size() - 1);
    end
    @(posedge clk);
    rf_valid <= 1'b0;
    rf_end   <= 1'b0;
  endtask : rf_frame
  task automatic rd_frame(input logic [7:0] k, input logic [7:0] mb, input bit diff);
    fb = {`TMR_RF_READ_FS};
    for (int i = 0; i < `TMR_ID_BYTES; i++) fb.push_back(8'h10 + 8'(i));
    fb.push_back(k);
    for (int i = 0; i < k; i++) fb = {fb, 8'h09, (diff && i == 1) ? 8'h01 : 8'h00};
    fb.push_back(mb);
    for (int i = 0; i < mb; i++) fb = {fb, 8'h80, 8'(i)};
    rf_frame();
  endtask : rd_frame
  task automatic l2_cmd(input logic [7:0] c, input int p);
    @(posedge clk);
    link2.cmd_ack <= 1'b1;
    @(posedge clk);
    link2.cmd_ack <= 1'b0;
    repeat (p) @(posedge clk);
    link2.cmd_valid <= 1'b1;
    link2.cmd_byte  <= c;
    link2.cmd_end   <= 1'b1;
    @(posedge clk);
    link2.cmd_valid <= 1'b0;
    link2.cmd_end   <= 1'b0;
  endtask : l2_cmd
  // silent or wrong host on the second link, timeout window checked
  task automatic host2(input bit q, input int p);
    int t0, r0, base, lim;
    t0 = n_to;
    r0 = n_rsp2;
    rd_frame(8'h01, 8'h02, 1'b0);
    for (int i = 0; i < 40 && link2.host_alert_n !== 1'b0; i++) @(posedge clk);
    if (q) l2_cmd(`TMR_CMD_QUERY, 0);
    if (q) wait_until(n_rsp2, r0 + 4, 40);
    if (p > 0) l2_cmd(8'h55, p);
    wait_until(n_to, t0 + 1, 600);
    @(posedge clk);
    base = q ? c_last : c_fall;
    lim = (q ? AL2 : QL2) * TICK + p;
    chk(32'(c_to - base >= lim - TICK && c_to - base <= lim + TICK + 4), 32'h1);
    chk({link2.host_alert_n, 8'(n_rsp2 - r0)}, {1'b1, q ? 8'h04 : 8'h00});
  endtask : host2
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  // ****
  // tests
  // ****
  initial begin
    {rst_n, rf_valid, rf_end, rf_typeb, sel2, ans_err, enc_mode, rf_byte} = '0;
    {link2.cmd_ack, link2.cmd_valid, link2.cmd_end, link2.cmd_byte} = '0;
    alert2_q = 1'b1;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      d0 = n_done;
      rq.delete();
      m = i[0] ? 8'h0F : 8'h01;
      a0 = n_busy;
      enc_mode <= 2'(i);
      ans_err <= i[0];
      rd_frame(i[1] ? 8'h0F : 8'h01, m, 1'b0);
      wait_until(n_done, d0 + 1, 2000);
      @(posedge clk);
      chk({8'(rq.size()), rq[0], rq[4]}, {8'd5, `TMR_RSP_OK, `TMR_RSP_OK});
      chk({rq[1], rq[3], len, rsp}, {2'b01, 2'(i), 4'h0, m, m, `TMR_RSP_OK});
      chk(ans_ok, !i[0]);
      chk({busy, n_busy > a0}, 2'b01);
    end
    for (int j = 0; j < 3; j++) begin
      d0 = n_done;
      rq.delete();
      rf_typeb <= (j > 0);
      fb = (j > 0) ? {8'h00, CODES[j], 8'h00, 8'h10, 8'h10} : {CODES[j], 8'h01, 8'h01};
      rf_frame();
      wait_until(n_done, d0 + 1, 2000);
      chk(rq[0], `TMR_RSP_OK);
    end
    rf_typeb <= 1'b0;
    for (int j = 0; j < 5; j++) begin
      e0 = n_rferr;
      a0 = n_alert;
      rd_frame(EK[j], EM[j], j == 4);
      wait_until(n_rferr, e0 + 1, 20);
      chk(n_alert - a0, 0);
    end
    sel2 <= 1'b1;
    host2(1'b0, 0);
    host2(1'b0, 40);
    host2(1'b1, 0);
    host2(1'b1, 40);
    chk(32'(n_tmo1), 32'h0000_0000);
    results();
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    results();
  end
endmodule : tmr_tunnel_mode_command_relay_tb
`default_nettype wire
